// ==== sac_align.sv ====
// alignment check, byte lanes, byte-load merge and direct address forming
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"
module sac_align (
  input  wire logic        acc_word,
  input  wire logic [15:0] acc_addr,
  input  wire logic [15:0] load_old,
  input  wire logic [15:0] load_data,
  input  wire logic [15:0] dir_field,
  input  wire logic        dir_mov,
  output logic             misaligned,
  output logic [1:0]       byte_en,
  output logic [15:0]      merged,
  output logic [15:0]      dir_addr
);
  // byte lane of an even or odd byte address
  function automatic logic [1:0] lane_of(input logic a0);
    lane_of = a0 ? 2'h2 : 2'h1;
  endfunction

  // a word at an odd address cannot be fetched in one access
  assign misaligned = acc_word & acc_addr[0];
  assign byte_en    = acc_word ? 2'h3 : lane_of(acc_addr[0]);
  // byte load lands in the low byte, high byte kept
  assign merged = lane_of(acc_addr[0]) == 2'h2 ?
                  {load_old[15:8], load_data[15:8]} :
                  {load_old[15:8], load_data[7:0]};
  // short field reaches only the near window, move takes the full field
  assign dir_addr = dir_mov ? dir_field : (dir_field & `SAC_NEAR_MASK);
endmodule
`default_nettype wire

// ==== sac_checker.sv ====
// stack and alignment checker: top level with registers and traps
//
// Notes on behaviour
// - word accesses need an even byte address
// - odd word access raises an address error trap
// - misaligned read completes, misaligned write suppressed
// - byte load writes low byte only
// - short direct field reaches near window only
// - move direct field reaches all X space
// - the register at offset two is the stack pointer; offset fifteen is unmapped
// - pointer marks next free word, grows upward
// - push stores then increments, pop pre-decrements
// - call push clears high byte
// - exception push carries status low byte high
// - limit bit zero always reads zero
// - pointer addresses compared against the limit
// - push at limit legal, next one traps
// - pointer address below floor traps underflow
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"
module sac_checker
  import sac_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [15:0]      REG_RDATA,
  input  wire logic        ACC_VALID,
  input  wire logic        ACC_WRITE,
  input  wire logic        ACC_WORD,
  input  wire logic [15:0] ACC_ADDR,
  input  wire logic [15:0] ACC_WDATA,
  input  wire logic        LOAD_EN,
  input  wire logic [15:0] LOAD_OLD,
  input  wire logic [15:0] LOAD_DATA,
  output logic [15:0]      LOAD_RESULT,
  input  wire logic [15:0] DIR_FIELD,
  input  wire logic        DIR_MOV,
  output logic [15:0]      DIR_ADDR,
  input  wire sac_op_type  STK_OP,
  input  wire logic [15:0] STK_WDATA,
  input  wire logic [7:0]  PC_HI,
  input  wire logic [7:0]  STATUS_LOW_BYTE,
  input  wire logic        SP_EA_VALID,
  input  wire logic [15:0] SP_EA,
  output logic [15:0]      STACK_POINTER,
  output logic [15:0]      MEM_ADDR,
  output logic [15:0]      MEM_WDATA,
  output logic [1:0]       MEM_BE,
  output logic             MEM_WE,
  output logic             MEM_RE,
  output logic             ADDR_ERR_REQ,
  output logic             STACK_ERR_REQ,
  output logic             IRQ
);
  sac_state_type cur;
  sac_state_type next_cur;

  logic        misaligned;
  logic [1:0]  byte_en;
  logic [15:0] merged;
  logic [15:0] dir_addr;
  logic [15:0] op_addr;
  logic [15:0] sp_new;
  logic        stack_err;
  logic        stk_busy;
  logic        data_acc;
  logic [1:0]  events;

  // checks on the plain data path
  sac_align u_align (
    .acc_word   (ACC_WORD),
    .acc_addr   (ACC_ADDR),
    .load_old   (LOAD_OLD),
    .load_data  (LOAD_DATA),
    .dir_field  (DIR_FIELD),
    .dir_mov    (DIR_MOV),
    .misaligned (misaligned),
    .byte_en    (byte_en),
    .merged     (merged),
    .dir_addr   (dir_addr)
  );

  // the stack pointer register drives every stack address
  sac_stack u_stack (
    .op        (STK_OP),
    .sp        (cur.sp),
    .limit     (cur.limit),
    .ea_valid  (SP_EA_VALID),
    .ea        (SP_EA),
    .op_addr   (op_addr),
    .sp_new    (sp_new),
    .stack_err (stack_err)
  );

  // a stack operation owns the memory port; a data access beside it
  // is dropped, the core never issues both in one cycle
  assign stk_busy = (STK_OP != SAC_OP_NONE);
  assign data_acc = ACC_VALID & ~stk_busy;

  // trap requests are pulses in the detecting cycle
  assign ADDR_ERR_REQ  = data_acc & misaligned;
  assign STACK_ERR_REQ = stack_err;
  assign events = {STACK_ERR_REQ, ADDR_ERR_REQ};

  // next state of registers and memory port
  always_comb begin
    next_cur = cur;
    next_cur.mem_we  = 1'b0;
    next_cur.mem_re  = 1'b0;
    next_cur.rd_data = 16'h0000;
    // register writes from software
    if (REG_WR) begin
      case (REG_ADDR)
        `SAC_OFS_LIMIT: next_cur.limit = {REG_WDATA[15:1], 1'b0};
        `SAC_OFS_SP: next_cur.sp = {REG_WDATA[15:1], 1'b0};
        `SAC_OFS_MASK: next_cur.mask = REG_WDATA[1:0];
        default: next_cur.mask = cur.mask;
      endcase
    end
    // register reads, answered one cycle later
    if (REG_RD) begin
      case (REG_ADDR)
        `SAC_OFS_LIMIT:  next_cur.rd_data = cur.limit;
        `SAC_OFS_SP:     next_cur.rd_data = cur.sp;
        `SAC_OFS_STATUS: next_cur.rd_data = {14'h0000, cur.status};
        `SAC_OFS_MASK:   next_cur.rd_data = {14'h0000, cur.mask};
        default:         next_cur.rd_data = 16'h0000;
      endcase
      if (REG_ADDR == `SAC_OFS_STATUS) begin
        next_cur.status = 2'h0;
      end
    end
    // new events win over a clearing read in the same cycle
    next_cur.status = next_cur.status | events;
    // stack operations
    case (STK_OP)
      SAC_OP_PUSH: begin
        next_cur.mem_addr  = op_addr;
        next_cur.mem_wdata = STK_WDATA;
        next_cur.mem_be    = 2'h3;
        next_cur.mem_we    = 1'b1;
        next_cur.sp        = sp_new;
      end
      SAC_OP_CALL: begin
        next_cur.mem_addr  = op_addr;
        next_cur.mem_wdata = {8'h00, PC_HI};
        next_cur.mem_be    = 2'h3;
        next_cur.mem_we    = 1'b1;
        next_cur.sp        = sp_new;
      end
      SAC_OP_EXC: begin
        next_cur.mem_addr  = op_addr;
        next_cur.mem_wdata = {STATUS_LOW_BYTE, PC_HI};
        next_cur.mem_be    = 2'h3;
        next_cur.mem_we    = 1'b1;
        next_cur.sp        = sp_new;
      end
      SAC_OP_POP: begin
        next_cur.mem_addr = op_addr;
        next_cur.mem_be   = 2'h3;
        next_cur.mem_re   = 1'b1;
        next_cur.sp       = sp_new;
      end
      default: begin
        next_cur.mem_be = cur.mem_be;
      end
    endcase
    // plain data access; a misaligned write is executed but not stored
    if (data_acc) begin
      next_cur.mem_addr  = ACC_ADDR;
      next_cur.mem_wdata = ACC_WDATA;
      next_cur.mem_be    = byte_en;
      next_cur.mem_we    = ACC_WRITE & ~misaligned;
      next_cur.mem_re    = ~ACC_WRITE;
    end
    // byte load merge keeps the destination high byte
    if (LOAD_EN) begin
      next_cur.load_result = merged;
    end
    next_cur.dir_addr = dir_addr;
  end

  // the limit comes up at a fixed value; software must load it
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur <= '{limit: `SAC_LIMIT_RST, sp: `SAC_SP_RST, status: 2'h0,
               mask: 2'h0, rd_data: 16'h0000, mem_addr: 16'h0000,
               mem_wdata: 16'h0000, mem_be: 2'h0, mem_we: 1'b0,
               mem_re: 1'b0, load_result: 16'h0000,
               dir_addr: 16'h0000};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state
  assign REG_RDATA     = cur.rd_data;
  assign LOAD_RESULT   = cur.load_result;
  assign DIR_ADDR      = cur.dir_addr;
  assign STACK_POINTER = cur.sp;
  assign MEM_ADDR      = cur.mem_addr;
  assign MEM_WDATA     = cur.mem_wdata;
  assign MEM_BE        = cur.mem_be;
  assign MEM_WE        = cur.mem_we;
  assign MEM_RE        = cur.mem_re;
  assign IRQ           = |(cur.status & cur.mask);

  default clocking dflt @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  // software writes seen by the checks below
  logic sp_wr;
  logic lim_wr;
  logic msk_wr;
  logic lim_push;
  assign sp_wr  = REG_WR & (REG_ADDR == `SAC_OFS_SP);
  assign lim_wr = REG_WR & (REG_ADDR == `SAC_OFS_LIMIT);
  assign msk_wr = REG_WR & (REG_ADDR == `SAC_OFS_MASK);
  // a push right at the limit, the limit itself left alone meanwhile
  assign lim_push = (STK_OP == SAC_OP_PUSH) && (STACK_POINTER == cur.limit)
                    && (STACK_POINTER >= `SAC_SFR_TOP) && !lim_wr;

  // odd word access from the core must trap at once
  AST_ODD_TRAPS: assert property (
    ACC_VALID && ACC_WORD && ACC_ADDR[0] && STK_OP == SAC_OP_NONE
    |-> ADDR_ERR_REQ)
    else $error("odd word access did not trap");

  // only odd word accesses may trap
  AST_EVEN_NO_TRAP: assert property (
    ADDR_ERR_REQ |-> ACC_WORD && ACC_ADDR[0] && ACC_VALID)
    else $error("address error without odd word access");

  // misaligned write reaches no memory
  AST_WR_SUPPRESS: assert property (
    ADDR_ERR_REQ && ACC_WRITE |=> !MEM_WE)
    else $error("misaligned write was stored");

  // misaligned read still goes out
  AST_RD_COMPLETES: assert property (
    ADDR_ERR_REQ && !ACC_WRITE |=> MEM_RE && MEM_ADDR == $past(ACC_ADDR))
    else $error("misaligned read did not complete");

  // byte load keeps the old high byte
  AST_BYTE_HIGH_KEPT: assert property (
    LOAD_EN |=> LOAD_RESULT[15:8] == $past(LOAD_OLD[15:8]))
    else $error("byte load changed high byte");

  // short direct field stays in the near window
  AST_NEAR_WINDOW: assert property (
    !DIR_MOV |=> DIR_ADDR == ($past(DIR_FIELD) & `SAC_NEAR_MASK))
    else $error("direct address left near window");

  // move field passes whole
  AST_MOV_FULL: assert property (
    DIR_MOV |=> DIR_ADDR == $past(DIR_FIELD))
    else $error("move address truncated");

  // push stores at the pointer and steps up one word
  AST_PUSH_STEP: assert property (
    STK_OP == SAC_OP_PUSH |=> MEM_WE && MEM_ADDR == $past(STACK_POINTER)
    && STACK_POINTER == $past(STACK_POINTER) + `SAC_WORD_STEP)
    else $error("push address or step wrong");

  // pop steps down before reading
  AST_POP_STEP: assert property (
    STK_OP == SAC_OP_POP |=> MEM_RE && MEM_ADDR == STACK_POINTER
    && STACK_POINTER == $past(STACK_POINTER) - `SAC_WORD_STEP)
    else $error("pop address or step wrong");

  // call push carries a clear high byte
  AST_CALL_ZERO: assert property (
    STK_OP == SAC_OP_CALL |=> MEM_WDATA == {8'h00, $past(PC_HI)})
    else $error("call push high byte not clear");

  // exception push carries the status low byte high
  AST_EXC_STATUS: assert property (
    STK_OP == SAC_OP_EXC
    |=> MEM_WDATA == {$past(STATUS_LOW_BYTE), $past(PC_HI)})
    else $error("exception push word wrong");

  // limit stays word aligned
  AST_LIMIT_EVEN: assert property (
    REG_WR && REG_ADDR == `SAC_OFS_LIMIT |=> cur.limit[0] == 1'b0)
    else $error("limit bit zero set");

  // push at the limit is legal
  AST_LIMIT_EDGE: assert property (
    lim_push |-> !STACK_ERR_REQ)
    else $error("push at the limit trapped");

  // the push after the one at the limit traps
  AST_LIMIT_NEXT: assert property (
    lim_push ##1 STK_OP == SAC_OP_PUSH |-> STACK_ERR_REQ)
    else $error("push past the limit not trapped");

  // pointer-made address below the floor traps
  AST_UNDERFLOW: assert property (
    SP_EA_VALID && STK_OP == SAC_OP_NONE && SP_EA < `SAC_SFR_TOP
    |-> STACK_ERR_REQ)
    else $error("underflow not trapped");

  // a trap event shows on the interrupt when unmasked
  AST_IRQ_FOLLOWS: assert property (
    STACK_ERR_REQ && cur.mask[`SAC_BIT_STK_ERR] && !msk_wr |=> IRQ)
    else $error("stack error did not raise interrupt");

  // a direct pointer write lands forced even
  AST_SP_WRITE: assert property (
    sp_wr && STK_OP == SAC_OP_NONE
    |=> STACK_POINTER == {$past(REG_WDATA[15:1]), 1'b0})
    else $error("pointer write lost or odd");

  // call and exception pushes store at the pointer and step up
  AST_FRAME_STEP: assert property (
    STK_OP == SAC_OP_CALL || STK_OP == SAC_OP_EXC
    |=> MEM_WE && MEM_ADDR == $past(STACK_POINTER)
    && STACK_POINTER == $past(STACK_POINTER) + `SAC_WORD_STEP)
    else $error("frame push address or step wrong");

  // a push above the limit traps
  AST_PUSH_OVER: assert property (
    STK_OP == SAC_OP_PUSH && STACK_POINTER > cur.limit |-> STACK_ERR_REQ)
    else $error("push above the limit not trapped");

  // other pointer-made addresses above the limit trap
  AST_EA_OVER: assert property (
    SP_EA_VALID && STK_OP == SAC_OP_NONE && SP_EA > cur.limit
    |-> STACK_ERR_REQ)
    else $error("pointer address above the limit not trapped");

  // a word access always enables both lanes
  AST_WORD_LANES: assert property (
    data_acc && ACC_WORD |=> MEM_BE == 2'h3)
    else $error("word access without both lanes");

  COV_ODD_WRITE: cover property (
    ADDR_ERR_REQ && ACC_WRITE ##1 !MEM_WE);
  COV_OVERFLOW: cover property (
    STK_OP == SAC_OP_PUSH && !STACK_ERR_REQ ##1
    STK_OP == SAC_OP_PUSH && STACK_ERR_REQ);
  COV_EXC_PUSH: cover property (STK_OP == SAC_OP_EXC);
  COV_UNDERFLOW: cover property (SP_EA_VALID && STACK_ERR_REQ);
  COV_STATUS_CLEAR: cover property (
    IRQ && REG_RD && REG_ADDR == `SAC_OFS_STATUS ##1 !IRQ);
endmodule
`default_nettype wire

// ==== sac_mem_model.sv ====
// data memory and trap collector on the far side of the checker
`timescale 1ns/1ps
`default_nettype none
module sac_mem_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  be,
  input  wire logic        we,
  input  wire logic        addr_err,
  input  wire logic        stk_err
);
  logic [15:0] mem [0:32767];
  int          addr_traps;
  int          stk_traps;

  // each lane is written only under its own enable
  always @(posedge clk) begin
    if (we && be[0]) begin
      mem[addr[15:1]][7:0] <= wdata[7:0];
    end
    if (we && be[1]) begin
      mem[addr[15:1]][15:8] <= wdata[15:8];
    end
  end

  // a request held longer than one cycle is counted once per cycle, so it shows up
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_traps <= 0;
      stk_traps <= 0;
    end else begin
      addr_traps <= addr_traps + int'(addr_err);
      stk_traps <= stk_traps + int'(stk_err);
    end
  end
endmodule
`default_nettype wire

// ==== sac_pkg.sv ====
// types shared by the stack and alignment checker
`default_nettype none
package sac_pkg;
  typedef enum logic [2:0] {
    SAC_OP_NONE = 3'b000,
    SAC_OP_PUSH = 3'b001,
    SAC_OP_POP  = 3'b010,
    SAC_OP_CALL = 3'b011,
    SAC_OP_EXC  = 3'b100
  } sac_op_type;

  typedef struct packed {
    logic [15:0] limit;
    logic [15:0] sp;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [15:0] rd_data;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [1:0]  mem_be;
    logic        mem_we;
    logic        mem_re;
    logic [15:0] load_result;
    logic [15:0] dir_addr;
  } sac_state_type;
endpackage
`default_nettype wire

// ==== sac_regs.svh ====
// register offsets, field positions and reset values of the checker
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
`define SAC_OFS_LIMIT    4'h0
`define SAC_OFS_SP       4'h2
`define SAC_OFS_STATUS   4'h4
`define SAC_OFS_MASK     4'h6
`define SAC_BIT_ADDR_ERR 0
`define SAC_BIT_STK_ERR  1
`define SAC_LIMIT_RST    16'h0000
`define SAC_SP_RST       16'h0800
`define SAC_SFR_TOP      16'h0800
`define SAC_NEAR_MASK    16'h1FFF
`define SAC_WORD_STEP    16'h0002
`endif

// ==== sac_stack.sv ====
// stack address generation and limit comparison
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"
module sac_stack
  import sac_pkg::*;
(
  input  wire sac_op_type  op,
  input  wire logic [15:0] sp,
  input  wire logic [15:0] limit,
  input  wire logic        ea_valid,
  input  wire logic [15:0] ea,
  output logic [15:0]      op_addr,
  output logic [15:0]      sp_new,
  output logic             stack_err
);
  logic        is_pop;
  logic        is_push;
  logic [15:0] chk_addr;
  logic        chk_on;

  assign is_pop  = (op == SAC_OP_POP);
  assign is_push = (op == SAC_OP_PUSH) | (op == SAC_OP_CALL) |
                   (op == SAC_OP_EXC);
  // pop pre-decrements, push stores at the pointer then steps up
  assign op_addr = is_pop ? sp - `SAC_WORD_STEP : sp;
  assign sp_new  = is_pop  ? sp - `SAC_WORD_STEP :
                   is_push ? sp + `SAC_WORD_STEP : sp;
  // the stack operation address, or ea when no stack operation runs, is held against limit and floor
  assign chk_on   = is_pop | is_push | ea_valid;
  assign chk_addr = (is_pop | is_push) ? op_addr : ea;
  // equal to the limit is still legal, so one more push traps
  assign stack_err = chk_on & ((chk_addr > limit) |
                               (chk_addr < `SAC_SFR_TOP));
endmodule
`default_nettype wire

// ==== test_stack_and_alignment_checker.sv ====
// self-checking bench for the stack and alignment checker
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.svh"
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      bad_count++; \
      $display("BAD %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module test_stack_and_alignment_checker
  import sac_pkg::*;
;
  logic       core_clk, rst_n, reg_wr, reg_rd, acc_valid, acc_write;
  logic       acc_word, load_en, dir_mov, sp_ea_valid, e;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, acc_addr, acc_wdata, load_old, load_data, d;
  logic [15:0] dir_field, stk_wdata, sp_ea, x;
  logic [7:0] pc_hi, slb;
  sac_op_type stk_op;
  logic [15:0] reg_rdata, load_result, dir_addr, stack_pointer;
  logic [15:0] mem_addr, mem_wdata;
  logic [1:0] mem_be;
  logic       mem_we, mem_re, addr_err_req, stack_err_req, irq;
  int         bad_count, cmp_count;

  sac_checker i_dut (
    .CORE_CLK(core_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .ACC_VALID(acc_valid), .ACC_WRITE(acc_write),
    .ACC_WORD(acc_word), .ACC_ADDR(acc_addr), .ACC_WDATA(acc_wdata),
    .LOAD_EN(load_en), .LOAD_OLD(load_old), .LOAD_DATA(load_data),
    .LOAD_RESULT(load_result), .DIR_FIELD(dir_field), .DIR_MOV(dir_mov),
    .DIR_ADDR(dir_addr), .STK_OP(stk_op), .STK_WDATA(stk_wdata),
    .PC_HI(pc_hi), .STATUS_LOW_BYTE(slb), .SP_EA_VALID(sp_ea_valid),
    .SP_EA(sp_ea), .STACK_POINTER(stack_pointer), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .MEM_BE(mem_be), .MEM_WE(mem_we),
    .MEM_RE(mem_re), .ADDR_ERR_REQ(addr_err_req),
    .STACK_ERR_REQ(stack_err_req), .IRQ(irq)
  );

  sac_mem_model i_mem (
    .clk(core_clk), .rst_n(rst_n), .addr(mem_addr), .wdata(mem_wdata),
    .be(mem_be), .we(mem_we), .addr_err(addr_err_req),
    .stk_err(stack_err_req)
  );

  // free-running core clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // register bus: one-cycle strobes, read data in the following cycle
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // data access; trap sampled in the request cycle, MEM_* after
  task automatic acc(input logic w, input logic wd, input logic [15:0] a,
                     input logic [15:0] v, output logic er);
    @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_word <= wd;
    acc_addr <= a;
    acc_wdata <= v;
    #1 er = addr_err_req;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    #1;
  endtask

  task automatic stk(input sac_op_type op, input logic [15:0] v,
                     input logic [7:0] ph, output logic er);
    @(posedge core_clk);
    stk_op <= op;
    stk_wdata <= v;
    pc_hi <= ph;
    slb <= 8'hA5;
    #1 er = stack_err_req;
    @(posedge core_clk);
    stk_op <= SAC_OP_NONE;
    #1;
  endtask

  task automatic ea(input logic [15:0] a, output logic er);
    @(posedge core_clk);
    sp_ea_valid <= 1'b1;
    sp_ea <= a;
    #1 er = stack_err_req;
    @(posedge core_clk);
    sp_ea_valid <= 1'b0;
    #1;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, acc_valid, acc_write, acc_word} = '0;
    {load_en, dir_mov, sp_ea_valid, reg_addr, pc_hi, slb} = '0;
    {reg_wdata, acc_addr, acc_wdata, load_old, load_data} = '0;
    {dir_field, stk_wdata, sp_ea} = '0;
    stk_op = SAC_OP_NONE;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, forced-even limit and pointer, unmapped slot
    rreg(`SAC_OFS_SP, d);
    `CHK("SP_RST", 16'h0800, d);
    rreg(`SAC_OFS_LIMIT, d);
    `CHK("LIM_RST", 16'h0000, d);
    wreg(`SAC_OFS_LIMIT, 16'h0805);
    rreg(`SAC_OFS_LIMIT, d);
    `CHK("LIM_B0", 16'h0804, d);
    rreg(4'h8, d);
    `CHK("UNMAPPED", 16'h0000, d);
    wreg(`SAC_OFS_SP, 16'h0901);
    rreg(`SAC_OFS_SP, d);
    `CHK("SP_WR", 16'h0900, d);
    `CHK("SP_PORT", 16'h0900, stack_pointer);
    wreg(`SAC_OFS_SP, 16'h0800);
    // even/odd word read and write; odd write must not land
    for (int i = 0; i < 4; i++) begin
      acc(i[0], 1'b1, 16'h0A00 + 16'(i[1]), 16'h1230 + 16'(i), e);
      `CHK("ADDR_ERR", i[1], e);
      `CHK("MEM_WE", i[0] & ~i[1], mem_we);
      `CHK("MEM_RE", ~i[0], mem_re);
      `CHK("MEM_BE", 2'h3, mem_be);
    end
    `CHK("NO_ODD_WR", 16'h1231, i_mem.mem[16'h0500]);
    `CHK("AE_PULSE", 1'b0, addr_err_req);
    `CHK("AE_COUNT", 2, i_mem.addr_traps);
    acc(1'b1, 1'b0, 16'h0A03, 16'h00EF, e);
    `CHK("BYTE_ODD", 2'b10, mem_be);
    `CHK("BYTE_ERR", 1'b0, e);
    // byte load keeps the destination's high byte
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      load_en <= 1'b1;
      acc_addr <= 16'h0A00 + 16'(i);
      load_old <= 16'hAB12;
      load_data <= 16'h3456;
      @(posedge core_clk);
      load_en <= 1'b0;
      #1 x = (i == 1) ? 16'hAB34 : 16'hAB56;
      `CHK("LOAD", x, load_result);
    end
    // short direct field confined to the near window, move field is not
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      dir_field <= 16'hFFFF;
      dir_mov <= i[0];
      @(posedge core_clk);
      #1 x = i[0] ? 16'hFFFF : 16'h1FFF;
      `CHK("DIR", x, dir_addr);
    end
    // pushes up to the limit (0x0804) and one past it
    for (int i = 0; i < 4; i++) begin
      x = 16'h0800 + 16'(2 * i);
      stk(SAC_OP_PUSH, 16'h1110 + 16'(i), 8'h00, e);
      `CHK("PUSH_ERR", (x > 16'h0804), e);
      `CHK("PUSH_ADDR", x, mem_addr);
      `CHK("PUSH_SP", x + 16'h0002, stack_pointer);
    end
    // the memory takes each push at the edge after MEM_WE shows
    @(posedge core_clk);
    #1;
    for (int i = 0; i < 4; i++) begin
      x = 16'h0800 + 16'(2 * i);
      `CHK("PUSH_MEM", 16'h1110 + 16'(i), i_mem.mem[x[15:1]]);
    end
    // pops back down and one below the floor
    for (int i = 0; i < 5; i++) begin
      x = 16'h0806 - 16'(2 * i);
      stk(SAC_OP_POP, 16'h0000, 8'h00, e);
      `CHK("POP_ERR", (x > 16'h0804 || x < 16'h0800), e);
      `CHK("POP_ADDR", x, mem_addr);
      `CHK("POP_RE", 1'b1, mem_re);
      `CHK("POP_SP", x, stack_pointer);
    end
    `CHK("SE_COUNT", 3, i_mem.stk_traps);
    wreg(`SAC_OFS_SP, 16'h0800);
    // call push clears the high byte, exception push carries status
    stk(SAC_OP_CALL, 16'h0000, 8'h12, e);
    `CHK("CALL_PUSH", 16'h0012, mem_wdata);
    stk(SAC_OP_EXC, 16'h0000, 8'h34, e);
    `CHK("EXC_PUSH", 16'hA534, mem_wdata);
    // other pointer-formed addresses; no limit write just before them
    ea(16'h07FE, e);
    `CHK("EA_LOW", 1'b1, e);
    ea(16'h0804, e);
    `CHK("EA_LIM", 1'b0, e);
    ea(16'h0806, e);
    `CHK("EA_HIGH", 1'b1, e);
    // sticky status, read-to-clear, mask gating of the interrupt
    rreg(`SAC_OFS_STATUS, d);
    `CHK("STATUS", 16'h0003, d);
    rreg(`SAC_OFS_STATUS, d);
    `CHK("ST_CLR", 16'h0000, d);
    wreg(`SAC_OFS_MASK, 16'h0001);
    acc(1'b0, 1'b1, 16'h0A01, 16'h0000, e);
    `CHK("IRQ_ON", 1'b1, irq);
    rreg(`SAC_OFS_STATUS, d);
    `CHK("ST_AE", 16'h0001, d);
    `CHK("IRQ_OFF", 1'b0, irq);
    ea(16'h0700, e);
    `CHK("IRQ_MASKED", 1'b0, irq);
    rreg(`SAC_OFS_STATUS, d);
    `CHK("ST_SE", 16'h0002, d);
    complete_run();
  end
endmodule
`default_nettype wire
